// *** rtl/smic_gain_map.sv ***
`timescale 1ns/10ps
module smic_gain_map (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [5:0] inputAmpGainCode,
    output logic signed [8:0] gainQuarterDb
);
    typedef struct packed {
        logic signed [8:0] gain;
    } smic_gain_state_t;

    smic_gain_state_t st;
    smic_gain_state_t next_st;

    // Linear law: code zero is the base, each code adds one step
    always_comb begin
        next_st = st;
        next_st.gain = smic_pkg::GAIN_BASE_QDB
            + smic_pkg::GAIN_STEP_QDB * $signed({3'b000, inputAmpGainCode}); // R15
    end

    // Registered so the mapped value is glitch free
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '{gain: 9'sh000};
        end else begin
            st <= next_st;
        end
    end

    assign gainQuarterDb = st.gain;
endmodule : smic_gain_map

// *** rtl/smic_link.sv ***
`timescale 1ns/10ps
module smic_link #(
    parameter logic [7:0] HALF_CYCLES = smic_pkg::MIC_HALF_CYCLES
) (
    input wire logic clkLink,
    input wire logic sysRstIn,
    input wire logic clockRequest,
    input wire logic micBitstreamIn,
    output logic micBitClock,
    output logic pairToggle,
    output logic pairLeft,
    output logic pairRight,
    output logic linkRunning
);
    typedef struct packed {
        logic rstSync1;
        logic rstSync2;
        logic enSync1;
        logic enSync2;
        logic datSync1;
        logic datSync2;
        logic [7:0] phaseCnt;
        logic micClk;
        logic leftBit;
        logic pairL;
        logic pairR;
        logic pairTog;
        logic haveLeft;
    } smic_link_state_t;

    // Sample point sits mid phase; the data sync lag is added back
    localparam logic [7:0] SAMPLE_AT = (HALF_CYCLES >> 1) + smic_pkg::DATA_SYNC_LAG;

    smic_link_state_t st;
    smic_link_state_t next_st;

    always_comb begin
        next_st = st;
        // Synchronisers: first stage feeds only the second
        next_st.rstSync1 = sysRstIn;
        next_st.rstSync2 = st.rstSync1;
        next_st.enSync1 = clockRequest;
        next_st.enSync2 = st.enSync1;
        next_st.datSync1 = micBitstreamIn;
        next_st.datSync2 = st.datSync1;
        if (st.rstSync2) begin
            next_st.enSync2 = 1'b0;
            next_st.phaseCnt = 8'h00;
            next_st.micClk = 1'b0;
            next_st.leftBit = 1'b0;
            next_st.pairL = 1'b0;
            next_st.pairR = 1'b0;
            next_st.pairTog = 1'b0;
            next_st.haveLeft = 1'b0;
        end else if (!st.enSync2) begin
            // Clock parked low while mic mode is off
            next_st.phaseCnt = 8'h00; // R04
            next_st.micClk = 1'b0; // R04
            next_st.haveLeft = 1'b0;
        end else begin
            // Equal high and low phases of HALF_CYCLES each
            if (st.phaseCnt == HALF_CYCLES - 8'h01) begin
                next_st.phaseCnt = 8'h00; // R18
                next_st.micClk = !st.micClk; // R05
            end else begin
                next_st.phaseCnt = st.phaseCnt + 8'h01;
            end
            // Mid-phase sample: high phase is left, low phase is right
            if (st.phaseCnt == SAMPLE_AT) begin
                if (st.micClk) begin
                    next_st.leftBit = st.datSync2; // R10
                    next_st.haveLeft = 1'b1;
                end else if (st.haveLeft) begin
                    // The low phase right after start has no left partner, so it forms no pair
                    next_st.pairL = st.leftBit; // R10 R12
                    next_st.pairR = st.datSync2; // R10
                    next_st.pairTog = !st.pairTog;
                end
            end
        end
    end

    // Sync reset taken from the synchronised system reset
    always_ff @(posedge clkLink) begin
        st <= next_st;
    end

    assign micBitClock = st.micClk; // R01
    assign pairToggle = st.pairTog;
    assign pairLeft = st.pairL;
    assign pairRight = st.pairR;
    assign linkRunning = st.enSync2;
endmodule : smic_link

// *** rtl/smic_pkg.sv ***
package smic_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_POWER = 6'h02;
    localparam logic [5:0] IDX_GAIN = 6'h03;
    localparam logic [5:0] IDX_STATUS = 6'h04;
    localparam logic [7:0] ADDR_POWER = {IDX_POWER, 2'b00};
    localparam logic [7:0] ADDR_GAIN = {IDX_GAIN, 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // Fields of power_control_one
    localparam int BIT_MIC_MODE = 7;
    localparam int BIT_LEFT_EN = 10;
    localparam int BIT_RIGHT_EN = 11;
    localparam int BIT_AMP_EN = 12;
    localparam logic [15:0] POWER_RESET = 16'h0000;

    // Fields of the gain and pin routing register
    localparam int GAIN_MSB = 5;
    localparam int BIT_GPIO_CLK = 8;
    localparam logic [5:0] GAIN_RESET = 6'h10;
    localparam logic GPIO_CLK_RESET = 1'b0;

    // Fields of the status register
    localparam int BIT_STAT_RUNNING = 0;
    localparam int BIT_STAT_FROM_MIC = 1;
    localparam int STAT_GAIN_LSB = 16;

    // Gain law in quarter-dB units: base plus step per code
    localparam logic signed [8:0] GAIN_BASE_QDB = -9'sd48;
    localparam logic signed [8:0] GAIN_STEP_QDB = 9'sd3;

    // Record sample format
    localparam int SAMPLE_W = 24;
    localparam logic [23:0] SAMPLE_POS = 24'h7fffff;
    localparam logic [23:0] SAMPLE_NEG = 24'h800001;

    // Link timing: link cycles per mic clock phase and the data sync lag
    localparam logic [7:0] MIC_HALF_CYCLES = 8'h10;
    localparam logic [7:0] DATA_SYNC_LAG = 8'h02;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : smic_pkg

// *** rtl/smic_top.sv ***
// What the document requires of this block, its software and the microphones
// R01: Data on shared pin, clock on GPIO
// R02: Software disables amp before mic mode
// R03: Mode bit selects mic or converter input
// R04: Mic clock held low when mode off
// R05: GPIO mic clock runs at record rate
// R06: Software enables record path and rate
// R07: Left enables converter/left, right enables right
// R08: Software sets enables per used channel
// R09: Left sends high phase, right low
// R10: Sample mid phase, high left, low right
// R11: Idle microphone releases the data line
// R12: At most two microphones, interleaved
// R13: Mic channels travel as stereo pair
// R14: Same digital volume for mic channels
// R15: Amp gain linear, -12 dB, 0.75 dB steps
// R16: Converter record samples are 24 bits
// R17: Amp enable bit twelve switches analogue path
// R18: Mic clock phases equal length
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module smic_top #(
    parameter logic [7:0] HALF_CYCLES = smic_pkg::MIC_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkLink,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic micBitstreamIn,
    output logic micBitClock,
    input wire logic [23:0] converterSample,
    input wire logic converterValid,
    output logic [23:0] recordLeft,
    output logic [23:0] recordRight,
    output logic recordValid,
    output logic recordFromMic,
    output logic leftRecordEnable,
    output logic rightRecordEnable,
    output logic inputAmpEnable,
    output logic [5:0] inputAmpGainCode,
    output logic signed [8:0] inputAmpGainQdb
);
    typedef struct packed {
        logic [15:0] power;
        logic [5:0] gainCode;
        logic gpioClk;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic togSync1;
        logic togSync2;
        logic togSeen;
        logic runSync1;
        logic runSync2;
        logic [23:0] recL;
        logic [23:0] recR;
        logic recValid;
    } smic_top_state_t;

    smic_top_state_t st;
    smic_top_state_t next_st;

    logic pairToggle;
    logic pairLeft;
    logic pairRight;
    logic linkRunning;
    logic clockRequest;
    logic signed [8:0] gainQdb;

    // One PDM bit becomes a full-scale record word
    function automatic logic [23:0] smic_bit_to_sample(input logic b);
        smic_bit_to_sample = b ? smic_pkg::SAMPLE_POS : smic_pkg::SAMPLE_NEG;
    endfunction : smic_bit_to_sample

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] smic_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        smic_merge = res;
    endfunction : smic_merge

    // Read decode; unmapped words read zero
    function automatic logic [31:0] smic_read(input smic_top_state_t s, input logic [7:0] addr,
                                              input logic signed [8:0] g);
        logic [31:0] d;
        d = 32'h00000000;
        case (addr)
            smic_pkg::ADDR_POWER: begin
                d[15:0] = s.power;
            end
            smic_pkg::ADDR_GAIN: begin
                d[smic_pkg::GAIN_MSB:0] = s.gainCode;
                d[smic_pkg::BIT_GPIO_CLK] = s.gpioClk;
            end
            smic_pkg::ADDR_STATUS: begin
                d[smic_pkg::BIT_STAT_RUNNING] = s.runSync2;
                d[smic_pkg::BIT_STAT_FROM_MIC] = s.power[smic_pkg::BIT_MIC_MODE];
                d[smic_pkg::STAT_GAIN_LSB +: 9] = g;
            end
            default: begin
                d = 32'h00000000;
            end
        endcase
        smic_read = d;
    endfunction : smic_read

    function automatic logic smic_mapped(input logic [7:0] addr);
        smic_mapped = (addr == smic_pkg::ADDR_POWER) || (addr == smic_pkg::ADDR_GAIN)
            || (addr == smic_pkg::ADDR_STATUS);
    endfunction : smic_mapped

    // Clock only runs when mic mode is on and a GPIO carries it
    assign clockRequest = st.power[smic_pkg::BIT_MIC_MODE] && st.gpioClk; // R04 R05

    smic_link #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_link (
        .clkLink(clkLink),
        .sysRstIn(sys_rst),
        .clockRequest(clockRequest),
        .micBitstreamIn(micBitstreamIn), // R01
        .micBitClock(micBitClock), // R01
        .pairToggle(pairToggle),
        .pairLeft(pairLeft),
        .pairRight(pairRight),
        .linkRunning(linkRunning)
    );

    smic_gain_map u_gain (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inputAmpGainCode(st.gainCode),
        .gainQuarterDb(gainQdb) // R15
    );

    // Bus handshakes: one write and one read at a time
    assign s_axi_awready = !st.awHeld && !st.bValid;
    assign s_axi_wready = !st.wHeld && !st.bValid;
    assign s_axi_arready = !st.rValid;

    always_comb begin
        logic pairEvent;
        logic micMode;
        logic [31:0] merged;
        pairEvent = 1'b0;
        micMode = 1'b0;
        merged = 32'h00000000;
        next_st = st;

        // Write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.awHeld && st.wHeld && !st.bValid) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp = smic_mapped(st.awAddr) ? smic_pkg::RESP_OKAY : smic_pkg::RESP_SLVERR;
            if (st.awAddr == smic_pkg::ADDR_POWER) begin
                merged = smic_merge({16'h0000, st.power}, st.wData, st.wStrb);
                next_st.power = merged[15:0]; // R03 R07 R17
            end else if (st.awAddr == smic_pkg::ADDR_GAIN) begin
                merged = smic_merge({23'h000000, st.gpioClk, 2'b00, st.gainCode}, st.wData, st.wStrb);
                next_st.gainCode = merged[smic_pkg::GAIN_MSB:0];
                next_st.gpioClk = merged[smic_pkg::BIT_GPIO_CLK];
            end
        end
        if (st.bValid && s_axi_bready) begin
            next_st.bValid = 1'b0;
        end

        // Read answers one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rValid = 1'b1;
            next_st.rData = smic_read(st, s_axi_araddr, gainQdb);
            next_st.rResp = smic_mapped(s_axi_araddr) ? smic_pkg::RESP_OKAY : smic_pkg::RESP_SLVERR;
        end else if (st.rValid && s_axi_rready) begin
            next_st.rValid = 1'b0;
        end

        // Pair event crosses as a toggle; the pair bits hold still for a whole
        // mic period, far longer than this sync takes, so they are read directly
        next_st.togSync1 = pairToggle;
        next_st.togSync2 = st.togSync1;
        next_st.togSeen = st.togSync2;
        pairEvent = st.togSync2 ^ st.togSeen;
        next_st.runSync1 = linkRunning;
        next_st.runSync2 = st.runSync1;

        // Record input select and channel enables
        micMode = st.power[smic_pkg::BIT_MIC_MODE];
        next_st.recValid = 1'b0;
        if (micMode) begin
            if (pairEvent) begin
                next_st.recValid = 1'b1; // R03 R13
                next_st.recL = st.power[smic_pkg::BIT_LEFT_EN] ? smic_bit_to_sample(pairLeft)
                    : 24'h000000; // R07
                next_st.recR = st.power[smic_pkg::BIT_RIGHT_EN] ? smic_bit_to_sample(pairRight)
                    : 24'h000000; // R07
            end
        end else if (converterValid && st.power[smic_pkg::BIT_LEFT_EN]) begin
            next_st.recValid = 1'b1; // R03 R07
            next_st.recL = converterSample; // R16
            next_st.recR = 24'h000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st <= '0;
            st.power <= smic_pkg::POWER_RESET;
            st.gainCode <= smic_pkg::GAIN_RESET;
            st.gpioClk <= smic_pkg::GPIO_CLK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid = st.bValid;
    assign s_axi_bresp = st.bResp;
    assign s_axi_rvalid = st.rValid;
    assign s_axi_rdata = st.rData;
    assign s_axi_rresp = st.rResp;
    // Record words feed the shared volume stage downstream
    assign recordLeft = st.recL; // R14
    assign recordRight = st.recR; // R14
    assign recordValid = st.recValid;
    assign recordFromMic = st.power[smic_pkg::BIT_MIC_MODE]; // R03
    assign leftRecordEnable = st.power[smic_pkg::BIT_LEFT_EN]; // R07
    assign rightRecordEnable = st.power[smic_pkg::BIT_RIGHT_EN]; // R07
    assign inputAmpEnable = st.power[smic_pkg::BIT_AMP_EN]; // R17
    assign inputAmpGainCode = st.gainCode;
    assign inputAmpGainQdb = gainQdb; // R15
endmodule : smic_top

// *** testbench/smic_mic_pair.sv ***
`timescale 1ns/10ps
module smic_mic_pair (
    input wire logic micBitClock,
    input wire logic leftBit,
    input wire logic rightBit,
    output logic dataLine
);
    initial dataLine = 1'b0;
    // Talking mic lets go at each phase change; the gap shows a flipped level, not a held one
    always @(micBitClock) begin
        dataLine = ~dataLine;
        #4 dataLine = micBitClock ? leftBit : rightBit;
    end
endmodule : smic_mic_pair

// *** testbench/smic_top_assertions.sv ***
`timescale 1ns/10ps
module smic_top_assertions #(
    parameter logic [7:0] HALF_CYCLES = smic_pkg::MIC_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkLink,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_arready,
    input wire logic micBitClock,
    input wire logic [23:0] converterSample,
    input wire logic converterValid,
    input wire logic [23:0] recordLeft,
    input wire logic [23:0] recordRight,
    input wire logic recordValid,
    input wire logic recordFromMic,
    input wire logic leftRecordEnable,
    input wire logic rightRecordEnable,
    input wire logic [5:0] inputAmpGainCode,
    input wire logic signed [8:0] inputAmpGainQdb
);
    logic [7:0] hiCount;
    // Length of the running high phase; the low phase before a start has no fixed length, so only highs count
    always_ff @(posedge clkLink) begin
        hiCount <= (sys_rst || !micBitClock) ? 8'h00 : hiCount + 8'h01;
    end
    sequence convIn;
        converterValid && !recordFromMic && leftRecordEnable;
    endsequence
    sequence convOut;
        recordValid && recordLeft == $past(converterSample) && recordRight == 24'h000000;
    endsequence
    conv_pass_a: assert property (@(posedge clk_sys) disable iff (sys_rst) convIn |=> convOut)
        else $error("converter sample not passed");
    conv_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        converterValid && !recordFromMic && !leftRecordEnable |=> !recordValid) else $error("left off passed");
    mic_left_a: assert property (@(posedge clk_sys) disable iff (sys_rst) recordValid && recordFromMic |->
        (leftRecordEnable ? recordLeft inside {24'h7fffff, 24'h800001} : recordLeft == 24'h000000))
        else $error("bad left mic word");
    mic_right_a: assert property (@(posedge clk_sys) disable iff (sys_rst) recordValid && recordFromMic |->
        (rightRecordEnable ? recordRight inside {24'h7fffff, 24'h800001} : recordRight == 24'h000000))
        else $error("bad right mic word");
    gain_law_a: assert property (@(posedge clk_sys) disable iff (sys_rst) !$past(sys_rst) |->
        inputAmpGainQdb == 9'h1d0 + 9'h003 * {3'h0, $past(inputAmpGainCode)}) else $error("gain law off");
    bresp_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    read_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst) s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    clk_idle_a: assert property (@(posedge clkLink) disable iff (sys_rst) !recordFromMic [*8] |-> !micBitClock)
        else $error("mic clock runs while off");
    phase_equal_a: assert property (@(posedge clkLink) disable iff (sys_rst)
        $fell(micBitClock) && recordFromMic |-> hiCount == HALF_CYCLES) else $error("high phase length off");
endmodule : smic_top_assertions
bind smic_top smic_top_assertions #(.HALF_CYCLES(HALF_CYCLES)) chk (.clk_sys, .sys_rst, .clkLink,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_arready,
    .micBitClock, .converterSample, .converterValid, .recordLeft, .recordRight, .recordValid, .recordFromMic,
    .leftRecordEnable, .rightRecordEnable, .inputAmpGainCode, .inputAmpGainQdb);

// *** testbench/stereo_pdm_mic_input_tb.sv ***
`timescale 1ns/10ps
module stereo_pdm_mic_input_tb;
    logic clk_sys, sys_rst, clkLink, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic micBitstreamIn, micBitClock, converterValid, recordValid, recordFromMic;
    logic leftRecordEnable, rightRecordEnable, inputAmpEnable, micLeft, micRight, enL, enR, micMode, bl, br;
    logic [23:0] converterSample, recordLeft, recordRight;
    logic [5:0] inputAmpGainCode, code;
    logic signed [8:0] inputAmpGainQdb;
    logic [8:0] q;
    logic [15:0] cfg;
    logic [47:0] expQ[$];
    int num_errors, checks_done, seed;
    smic_top #(.HALF_CYCLES(8'h10)) dut (.clk_sys, .sys_rst, .clkLink, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .micBitstreamIn, .micBitClock, .converterSample, .converterValid, .recordLeft,
        .recordRight, .recordValid, .recordFromMic, .leftRecordEnable, .rightRecordEnable, .inputAmpEnable,
        .inputAmpGainCode, .inputAmpGainQdb);
    smic_mic_pair mic (.micBitClock, .leftBit(micLeft), .rightBit(micRight), .dataLine(micBitstreamIn));
    // Two clocks with no phase relation
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        clkLink = 1'b0;
        #1.7;
        forever #3 clkLink = ~clkLink;
    end
    function automatic logic [23:0] pdm(input logic b, input logic en);
        return en ? (b ? 24'h7fffff : 24'h800001) : 24'h000000;
    endfunction : pdm
    task automatic chkWord(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chkWord
    task automatic chkPair(input string n, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chkPair
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // Address and data offered together; each dropped once taken
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chkWord("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chkWord("rdata", e & m, s_axi_rdata & m);
        chkWord("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : axiRd
    task automatic setPower(input logic [15:0] v);
        axiWr(smic_pkg::ADDR_POWER, {16'h0, v}, 4'hf, smic_pkg::RESP_OKAY);
        enL = v[10];
        enR = v[11];
        micMode = v[7];
    endtask : setPower
    // Random converter traffic; ignored while the mic path is selected
    task automatic convBurst(input int n);
        logic [23:0] s;
        logic v;
        repeat (n) begin
            @(posedge clk_sys);
            s = 24'($random(seed));
            v = 1'($random(seed));
            converterSample <= s;
            converterValid <= v;
            if (v && enL && !micMode) expQ.push_back({s, 24'h0});
        end
        @(posedge clk_sys);
        converterValid <= 1'b0;
    endtask : convBurst
    // New stereo pair at every mic clock rise: left bit now, right bit in the following low phase
    always @(posedge micBitClock) begin
        bl = 1'($random(seed));
        br = 1'($random(seed));
        micLeft <= bl;
        micRight <= br;
        expQ.push_back({pdm(bl, enL), pdm(br, enR)});
    end
    always @(posedge clk_sys) begin
        if (recordValid === 1'b1) begin
            if (expQ.size() == 0) begin
                num_errors++;
                $display("BAD record expected none seen %h", {recordLeft, recordRight});
            end else begin
                chkPair("record", expQ.pop_front(), {recordLeft, recordRight});
            end
        end
    end
    initial begin
        #500000;
        num_errors++;
        close_out();
    end
    initial begin
        seed = 32'h45d8;
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, converterSample, converterValid} = 77'h0;
        {micLeft, micRight, enL, enR, micMode} = 5'h0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        axiRd(smic_pkg::ADDR_POWER, 32'h0, 32'hffffffff, smic_pkg::RESP_OKAY);
        axiRd(smic_pkg::ADDR_GAIN, 32'h10, 32'h1ff, smic_pkg::RESP_OKAY);
        axiRd(8'h40, 32'h0, 32'hffffffff, smic_pkg::RESP_SLVERR);
        axiWr(8'h40, 32'hffffffff, 4'hf, smic_pkg::RESP_SLVERR);
        axiWr(smic_pkg::ADDR_POWER, 32'hffffffff, 4'h2, smic_pkg::RESP_OKAY);
        axiRd(smic_pkg::ADDR_POWER, 32'hff00, 32'hffffffff, smic_pkg::RESP_OKAY);
        chkWord("enables", 32'h7, {29'h0, inputAmpEnable, rightRecordEnable, leftRecordEnable});
        setPower(16'h0000);
        // Gain ends of the range plus random codes, seen through register and status
        for (int i = 0; i < 5; i++) begin
            code = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($random(seed));
            q = 9'h1d0 + 9'h003 * {3'h0, code};
            axiWr(smic_pkg::ADDR_GAIN, {26'h0, code}, 4'h1, smic_pkg::RESP_OKAY);
            chkWord("ampCode", {26'h0, code}, {26'h0, inputAmpGainCode});
            axiRd(smic_pkg::ADDR_GAIN, {26'h0, code}, 32'h1ff, smic_pkg::RESP_OKAY);
            axiRd(smic_pkg::ADDR_STATUS, {7'h0, q, 16'h0}, 32'h01ff0003, smic_pkg::RESP_OKAY);
        end
        setPower(16'h0400);
        convBurst(20);
        setPower(16'h0000);
        convBurst(10);
        chkWord("pending", 32'h0, 32'(expQ.size()));
        axiWr(smic_pkg::ADDR_GAIN, 32'h110, 4'h3, smic_pkg::RESP_OKAY);
        // Every enable combination; amp stays off before mic mode
        for (int i = 0; i < 4; i++) begin
            cfg = 16'h0080 | (16'(3 - i) << 10);
            setPower(cfg);
            chkWord("fromMic", 32'h1, {31'h0, recordFromMic});
            convBurst(150);
            axiRd(smic_pkg::ADDR_STATUS, 32'h3, 32'h3, smic_pkg::RESP_OKAY);
            setPower(cfg & 16'hff7f);
            repeat (40) @(posedge clk_sys);
            expQ.delete();
        end
        axiRd(smic_pkg::ADDR_STATUS, 32'h0, 32'h3, smic_pkg::RESP_OKAY);
        chkWord("micClock", 32'h0, {31'h0, micBitClock});
        close_out();
    end
endmodule : stereo_pdm_mic_input_tb
